// >>> src/lrp_pkg.sv
package lrp_pkg;
    // configuration flash word addresses, two variants
    localparam logic [31:0] ADDR_WORD_SMALL = 32'h0007e0b0;
    localparam logic [31:0] ADDR_COPY_SMALL = 32'h0007e0c0;
    localparam logic [31:0] ADDR_WORD_LARGE = 32'h000fe0b0;
    localparam logic [31:0] ADDR_COPY_LARGE = 32'h000fe0c0;

    // protection word encodings
    localparam logic [31:0] ENC_LEVEL_ZERO  = 32'hffffffff;
    localparam logic [31:0] ENC_LEVEL_ONE   = 32'heeba04c3;
    localparam logic [31:0] ENC_LEVEL_TWO   = 32'h49398d8b;
    localparam logic [31:0] ENC_LEVEL_THREE = 32'hb0abb703;

    // register offsets on the plain register port
    localparam logic [7:0] OFS_LEVEL_WORD  = 8'h00;
    localparam logic [7:0] OFS_STATUS      = 8'h04;
    localparam logic [7:0] OFS_LOADER_ARG  = 8'h08;
    localparam logic [7:0] OFS_LOADER_RES  = 8'h0c;
    localparam logic [31:0] RST_LEVEL_WORD = 32'hffffffff;

    // status field positions
    localparam int ST_LEVEL_LSB   = 0;
    localparam int ST_DBG_EN_BIT  = 3;
    localparam int ST_DBG_LCK_BIT = 4;
    localparam int ST_ISP_EN_BIT  = 5;
    localparam int ST_DONE_BIT    = 6;

    // loader argument fields
    localparam int ARG_TAG_LSB   = 24;
    localparam int ARG_MODE_LSB  = 20;
    localparam int ARG_IFACE_LSB = 16;
    localparam int ARG_IMG_LSB   = 0;
    localparam logic [7:0] ARG_TAG_VALUE = 8'heb;
    localparam logic [3:0] MODE_PASSIVE  = 4'h0;
    localparam logic [3:0] MODE_ISP      = 4'h1;
    localparam logic [3:0] IFACE_MAX     = 4'h5;

    // decoded protection levels, ordered by restriction
    typedef enum logic [2:0] {
        LVL_ZERO  = 3'b000,
        LVL_ONE   = 3'b001,
        LVL_TWO   = 3'b010,
        LVL_THREE = 3'b011,
        LVL_BAD   = 3'b100
    } lrp_level_type;

    // mailbox command codes, bit index into the allowed mask
    localparam int CMD_COUNT = 10;
    localparam logic [3:0] CMD_START_SESSION = 4'h0;
    localparam logic [3:0] CMD_EXIT_SESSION  = 4'h1;
    localparam logic [3:0] CMD_REPORT_LEVEL  = 4'h2;
    localparam logic [3:0] CMD_MASS_ERASE    = 4'h3;
    localparam logic [3:0] CMD_ENTER_PROG    = 4'h4;
    localparam logic [3:0] CMD_FAIL_ANALYSIS = 4'h5;
    localparam logic [3:0] CMD_START_DEBUG   = 4'h6;
    localparam logic [3:0] CMD_WRITE_WORD    = 4'h7;
    localparam logic [3:0] CMD_READ_WORD     = 4'h8;
    localparam logic [3:0] CMD_ERASE_SECTOR  = 4'h9;

    localparam logic [9:0] MASK_DEVELOP   = 10'h3ff;
    localparam logic [9:0] MASK_LEVEL_ONE = 10'h03f;
    localparam logic [9:0] MASK_LEVEL_TWO = 10'h02f;
    localparam logic [9:0] MASK_NONE      = 10'h000;

    // start-up sequence states
    typedef enum logic [2:0] {
        ST_IDLE     = 3'b000,
        ST_REQ_WORD = 3'b001,
        ST_WAIT_WORD= 3'b010,
        ST_REQ_COPY = 3'b011,
        ST_WAIT_COPY= 3'b100,
        ST_COMPARE  = 3'b101,
        ST_RUN      = 3'b110
    } lrp_state_type;
endpackage : lrp_pkg

// >>> src/lrp_level_decode.sv
`timescale 1ns/1ps
// pure decode of a protection word into level and gating
module lrp_level_decode (
    // protection word in
    input  wire logic [31:0]          word,
    // decoded outputs
    output lrp_pkg::lrp_level_type    level,
    output logic                      dbg_enable,
    output logic                      dbg_locked,
    output logic                      isp_enable,
    output logic [9:0]                cmd_mask
);
    // rank the encodings; anything unknown behaves as the strictest level
    assign level = (word == lrp_pkg::ENC_LEVEL_ZERO)  ? lrp_pkg::LVL_ZERO  :
                   (word == lrp_pkg::ENC_LEVEL_ONE)   ? lrp_pkg::LVL_ONE   :
                   (word == lrp_pkg::ENC_LEVEL_TWO)   ? lrp_pkg::LVL_TWO   :
                   (word == lrp_pkg::ENC_LEVEL_THREE) ? lrp_pkg::LVL_THREE : lrp_pkg::LVL_BAD;

    // debug only open at level zero; level one stays unlocked
    assign dbg_enable = (level == lrp_pkg::LVL_ZERO);
    assign dbg_locked = (level != lrp_pkg::LVL_ZERO) && (level != lrp_pkg::LVL_ONE);
    // programming mode refused at level three and for unknown words
    assign isp_enable = (level != lrp_pkg::LVL_THREE) && (level != lrp_pkg::LVL_BAD);

    // mailbox command set per level
    assign cmd_mask = (level == lrp_pkg::LVL_ZERO) ? lrp_pkg::MASK_DEVELOP   :
                      (level == lrp_pkg::LVL_ONE)  ? lrp_pkg::MASK_LEVEL_ONE :
                      (level == lrp_pkg::LVL_TWO)  ? lrp_pkg::MASK_LEVEL_TWO : lrp_pkg::MASK_NONE;
endmodule : lrp_level_decode

// >>> src/lrp_policy.sv
`timescale 1ns/1ps
// Functional notes
// - read protection word and copy at start-up; mismatch forces chip reset
// - on match load word into the software readable and writable register
// - small part fetches 0x0007_e0b0/c0, large part 0x000f_e0b0/c0
// - all-ones erased word means level zero, no protection
// - 0xeeba_04c3 is level one: debug off, unlocked, limited mailbox
// - 0x4939_8d8b is level two: debug off and locked, limited mailbox
// - 0xb0ab_b703 is level three: debug off, locked, no mailbox
// - any other word acts like level three, programming mode disabled
// - development state accepts every mailbox command
// - level one accepts session, report, erase, programming, analysis commands
// - level two accepts session, report, erase, analysis; erase includes sector zero
// - level three or bricked locks part, mailbox fully unavailable
// - level chooses boot flow, debug enable and lock, mailbox set
// - after loader hand-off level is checked again for programming commands
// - argument bits 23:20 pick passive or programming boot mode
// - life-cycle state may only advance, never relax
module lrp_policy #(
    parameter bit LARGE_VARIANT = 1'b0
) (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // configuration flash read port
    output logic             flash_rd,
    output logic [31:0]      flash_addr,
    input  wire logic        flash_valid,
    input  wire logic [31:0] flash_data,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata,
    // chip reset request
    output logic             chip_reset,
    // policy outputs
    output logic             dbg_enable,
    output logic             dbg_locked,
    output logic             isp_enable,
    output logic             boot_ready,
    output logic [1:0]       level_out,
    // debug mailbox
    input  wire logic        mbx_valid,
    input  wire logic [3:0]  mbx_cmd,
    output logic             mbx_accept,
    output logic             mbx_reject,
    // loader entry result
    output logic             loader_go,
    output logic             loader_isp,
    output logic [3:0]       loader_iface
);
    lrp_pkg::lrp_state_type state_reg, state_next;
    logic [31:0] word_reg, word_next;
    logic [31:0] copy_reg, copy_next;
    logic [31:0] level_word_reg, level_word_next;
    logic [2:0]  level_cap_reg, level_cap_next;
    logic [9:0]  mask_reg, mask_next;
    logic        dbg_en_reg, dbg_lck_reg, isp_en_reg;
    logic        done_reg;
    logic        chip_reset_reg;
    logic [31:0] rdata_reg, rdata_next;
    logic [31:0] arg_reg;
    logic        arg_ok_reg, arg_isp_reg;
    logic [3:0]  arg_iface_reg;
    logic        accept_reg, reject_reg;

    lrp_pkg::lrp_level_type dec_level;
    logic        dec_dbg_en, dec_dbg_lck, dec_isp_en;
    logic [9:0]  dec_mask_boot;
    lrp_pkg::lrp_level_type wr_level;
    logic        wr_dbg_en, wr_dbg_lck, wr_isp_en;
    logic [9:0]  wr_mask;

    // rank of a decoded level: higher is more restrictive
    function automatic logic [2:0] rank_of(input lrp_pkg::lrp_level_type lv);
        rank_of = (lv == lrp_pkg::LVL_BAD) ? 3'h3 : 3'(lv);
    endfunction : rank_of

    // decode of the start-up word, later of each accepted rewrite
    lrp_level_decode u_dec_boot (
        .word       (word_reg),
        .level      (dec_level),
        .dbg_enable (dec_dbg_en),
        .dbg_locked (dec_dbg_lck),
        .isp_enable (dec_isp_en),
        .cmd_mask   ()
    );

    // decode of a value software is writing, used only for the advance check
    lrp_level_decode u_dec_write (
        .word       (reg_wdata),
        .level      (wr_level),
        .dbg_enable (wr_dbg_en),
        .dbg_locked (wr_dbg_lck),
        .isp_enable (wr_isp_en),
        .cmd_mask   (wr_mask)
    );

    wire [31:0] addr_word = LARGE_VARIANT ? lrp_pkg::ADDR_WORD_LARGE : lrp_pkg::ADDR_WORD_SMALL;
    wire [31:0] addr_copy = LARGE_VARIANT ? lrp_pkg::ADDR_COPY_LARGE : lrp_pkg::ADDR_COPY_SMALL;
    wire        words_match = (word_reg == copy_reg);

    // register decode
    wire sel_word = (reg_addr == lrp_pkg::OFS_LEVEL_WORD);
    wire sel_stat = (reg_addr == lrp_pkg::OFS_STATUS);
    wire sel_arg  = (reg_addr == lrp_pkg::OFS_LOADER_ARG);
    wire sel_res  = (reg_addr == lrp_pkg::OFS_LOADER_RES);
    // a write may only keep or raise the restriction rank
    // compared with the stored word, not the boot level, so a raise cannot be undone later
    wire wr_advances = rank_of(wr_level) >= rank_of(dec_level);
    wire wr_word_ok  = reg_wr && sel_word && done_reg && wr_advances;

    // loader argument field extraction
    wire [7:0] arg_tag   = reg_wdata[lrp_pkg::ARG_TAG_LSB +: 8];
    wire [3:0] arg_mode  = reg_wdata[lrp_pkg::ARG_MODE_LSB +: 4];
    wire [3:0] arg_iface = reg_wdata[lrp_pkg::ARG_IFACE_LSB +: 4];
    wire [3:0] arg_img   = reg_wdata[lrp_pkg::ARG_IMG_LSB +: 4];
    wire tag_ok   = (arg_tag == lrp_pkg::ARG_TAG_VALUE);
    wire mode_ok  = (arg_mode == lrp_pkg::MODE_PASSIVE) || (arg_mode == lrp_pkg::MODE_ISP);
    wire iface_ok = (arg_iface <= lrp_pkg::IFACE_MAX);
    wire arg_good = tag_ok && mode_ok && iface_ok && (arg_img == 4'h0);
    // programming entry only if the captured level still permits it
    wire arg_isp  = (arg_mode == lrp_pkg::MODE_ISP) && isp_en_reg;

    // start-up sequence
    always_comb begin
        state_next      = state_reg;
        word_next       = word_reg;
        copy_next       = copy_reg;
        level_word_next = level_word_reg;
        level_cap_next  = level_cap_reg;
        mask_next       = mask_reg;
        case (state_reg)
            lrp_pkg::ST_IDLE: begin
                state_next = lrp_pkg::ST_REQ_WORD;
            end
            lrp_pkg::ST_REQ_WORD: begin
                state_next = lrp_pkg::ST_WAIT_WORD;
            end
            lrp_pkg::ST_WAIT_WORD: begin
                if (flash_valid) begin
                    word_next  = flash_data;
                    state_next = lrp_pkg::ST_REQ_COPY;
                end
            end
            lrp_pkg::ST_REQ_COPY: begin
                state_next = lrp_pkg::ST_WAIT_COPY;
            end
            lrp_pkg::ST_WAIT_COPY: begin
                if (flash_valid) begin
                    copy_next  = flash_data;
                    state_next = lrp_pkg::ST_COMPARE;
                end
            end
            lrp_pkg::ST_COMPARE: begin
                if (words_match) begin
                    level_word_next = word_reg;
                    level_cap_next  = 3'(dec_level);
                    // fix mailbox set from the level
                    mask_next       = dec_mask_boot;
                    state_next      = lrp_pkg::ST_RUN;
                end
            end
            lrp_pkg::ST_RUN: begin
                // software may only keep or tighten the stored word
                if (wr_word_ok) begin
                    level_word_next = reg_wdata;
                    word_next       = reg_wdata; // keeps the rank check on the stored word
                end
            end
            default: begin
                state_next = lrp_pkg::ST_IDLE;
            end
        endcase
    end

    // boot mask recomputed from the boot decode
    // full set in development
    assign dec_mask_boot = (dec_level == lrp_pkg::LVL_ZERO) ? lrp_pkg::MASK_DEVELOP   :
                           (dec_level == lrp_pkg::LVL_ONE)  ? lrp_pkg::MASK_LEVEL_ONE :
                           (dec_level == lrp_pkg::LVL_TWO)  ? lrp_pkg::MASK_LEVEL_TWO : lrp_pkg::MASK_NONE;

    // read mux, one cycle latency; unmapped reads give zero
    wire [31:0] status_word = {25'h0, done_reg, isp_en_reg, dbg_lck_reg, dbg_en_reg, level_cap_reg};
    wire [31:0] result_word = {26'h0, arg_iface_reg, arg_isp_reg, arg_ok_reg};
    assign rdata_next = !reg_rd  ? 32'h0 :
                        sel_word ? level_word_reg :
                        sel_stat ? status_word :
                        sel_arg  ? arg_reg :
                        sel_res  ? result_word : 32'h0;

    // mailbox gating by the captured command set
    wire mbx_allowed = done_reg && (mbx_cmd < 4'd10) && mask_reg[mbx_cmd];

    // sequence and captured state
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_reg      <= lrp_pkg::ST_IDLE;
            word_reg       <= 32'h0;
            copy_reg       <= 32'h0;
            level_word_reg <= lrp_pkg::RST_LEVEL_WORD;
            level_cap_reg  <= 3'h3;
            mask_reg       <= lrp_pkg::MASK_NONE;
        end else begin
            state_reg      <= state_next;
            word_reg       <= word_next;
            copy_reg       <= copy_next;
            level_word_reg <= level_word_next;
            level_cap_reg  <= level_cap_next;
            mask_reg       <= mask_next;
        end
    end

    // gating flags held until reset; strict until the compare passes
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dbg_en_reg  <= 1'b0;
            dbg_lck_reg <= 1'b1;
            isp_en_reg  <= 1'b0;
            done_reg    <= 1'b0;
        end else if (state_reg == lrp_pkg::ST_COMPARE && words_match) begin
            dbg_en_reg  <= dec_dbg_en;
            dbg_lck_reg <= dec_dbg_lck;
            isp_en_reg  <= dec_isp_en;
            done_reg    <= 1'b1;
        end
    end

    // mismatch requests chip reset; held until reset arrives
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            chip_reset_reg <= 1'b0;
        end else if (state_reg == lrp_pkg::ST_COMPARE && !words_match) begin
            chip_reset_reg <= 1'b1;
        end
    end

    // register read data and loader argument
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata_reg     <= 32'h0;
            arg_reg       <= 32'h0;
            arg_ok_reg    <= 1'b0;
            arg_isp_reg   <= 1'b0;
            arg_iface_reg <= 4'h0;
        end else begin
            rdata_reg <= rdata_next;
            if (reg_wr && sel_arg) begin
                arg_reg       <= reg_wdata;
                arg_ok_reg    <= arg_good;
                arg_isp_reg   <= arg_good && arg_isp;
                arg_iface_reg <= arg_good ? arg_iface : 4'h0;
            end
        end
    end

    // mailbox answer one cycle after the command
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            accept_reg <= 1'b0;
            reject_reg <= 1'b0;
        end else begin
            accept_reg <= mbx_valid && mbx_allowed;
            reject_reg <= mbx_valid && !mbx_allowed;
        end
    end

    // flash fetch strobe, one cycle per word
    assign flash_rd     = (state_reg == lrp_pkg::ST_REQ_WORD) || (state_reg == lrp_pkg::ST_REQ_COPY);
    assign flash_addr   = (state_reg == lrp_pkg::ST_REQ_COPY) ? addr_copy : addr_word;
    assign reg_rdata    = rdata_reg;
    assign chip_reset   = chip_reset_reg;
    assign dbg_enable   = dbg_en_reg;
    assign dbg_locked   = dbg_lck_reg;
    assign isp_enable   = isp_en_reg;
    assign boot_ready   = done_reg;
    assign level_out    = level_cap_reg[1:0] | {2{level_cap_reg[2]}};
    assign mbx_accept   = accept_reg;
    assign mbx_reject   = reject_reg;
    // loader entry flag mirrors the result register bit and holds until the next argument write
    assign loader_go    = arg_ok_reg;
    assign loader_isp   = arg_isp_reg;
    assign loader_iface = arg_iface_reg;
endmodule : lrp_policy

// >>> verif/lrp_policy_checker.sv
`timescale 1ns/1ps
// port-level watcher for the protection policy block
module lrp_policy_checker #(
    parameter bit LARGE_VARIANT = 1'b0
) (
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        rst,
    // flash request
    input wire logic        flash_rd,
    input wire logic [31:0] flash_addr,
    // policy state
    input wire logic        chip_reset,
    input wire logic        dbg_enable,
    input wire logic        dbg_locked,
    input wire logic        boot_ready,
    input wire logic [1:0]  level_out,
    // mailbox
    input wire logic        mbx_valid,
    input wire logic [3:0]  mbx_cmd,
    input wire logic        mbx_accept,
    input wire logic        mbx_reject
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // only the two locations of the chosen variant may be fetched
    wire logic [31:0] word_addr = LARGE_VARIANT ? lrp_pkg::ADDR_WORD_LARGE : lrp_pkg::ADDR_WORD_SMALL;
    wire logic [31:0] copy_addr = LARGE_VARIANT ? lrp_pkg::ADDR_COPY_LARGE : lrp_pkg::ADDR_COPY_SMALL;

    a_flash_addr_legal: assert property (flash_rd |-> flash_addr == word_addr || flash_addr == copy_addr)
        else $error("flash read at unexpected address");
    a_mbx_one_answer: assert property (mbx_valid |=> mbx_accept != mbx_reject)
        else $error("mailbox request without a single answer");
    a_mbx_early_refuse: assert property (!boot_ready && mbx_valid |=> mbx_reject)
        else $error("mailbox accepted before start-up finished");
    a_lvl3_mbx_closed: assert property (boot_ready && level_out == 2'd3 && mbx_valid |=> mbx_reject)
        else $error("mailbox answered at the top level");
    a_lvl2_no_prog: assert property (boot_ready && level_out == 2'd2 && mbx_valid
        && mbx_cmd == lrp_pkg::CMD_ENTER_PROG |=> mbx_reject)
        else $error("programming entry accepted at level two");
    a_limited_no_debug: assert property (boot_ready && level_out inside {2'd1, 2'd2} && mbx_valid
        && mbx_cmd >= lrp_pkg::CMD_START_DEBUG |=> mbx_reject)
        else $error("development command accepted at a limited level");
    a_lvl0_full_set: assert property (boot_ready && level_out == 2'd0 && mbx_valid
        && mbx_cmd <= lrp_pkg::CMD_ERASE_SECTOR |=> mbx_accept)
        else $error("command refused in the open state");
    a_reset_sticky: assert property (chip_reset |=> chip_reset && !boot_ready)
        else $error("mismatch reset dropped or boot went on");
    a_level_held: assert property ($past(boot_ready) && boot_ready |-> $stable(level_out) && $stable(dbg_locked))
        else $error("decoded level changed after start-up");
    a_lvl0_debug_open: assert property (boot_ready && level_out == 2'd0 |-> dbg_enable && !dbg_locked)
        else $error("debug not open at level zero");
    a_lvl1_unlocked: assert property (boot_ready && level_out == 2'd1 |-> !dbg_enable && !dbg_locked)
        else $error("debug gating wrong at level one");
    a_high_locked: assert property (boot_ready && level_out >= 2'd2 |-> !dbg_enable && dbg_locked)
        else $error("debug not locked at a high level");

    c_boot_done: cover property ($rose(boot_ready));
    c_mismatch: cover property ($rose(chip_reset));
    c_accept: cover property (mbx_accept && level_out == 2'd1);
endmodule : lrp_policy_checker

bind lrp_policy lrp_policy_checker #(.LARGE_VARIANT(LARGE_VARIANT)) u_chk (
    .ref_clk(ref_clk), .rst(rst), .flash_rd(flash_rd), .flash_addr(flash_addr), .chip_reset(chip_reset),
    .dbg_enable(dbg_enable), .dbg_locked(dbg_locked), .boot_ready(boot_ready), .level_out(level_out),
    .mbx_valid(mbx_valid), .mbx_cmd(mbx_cmd), .mbx_accept(mbx_accept), .mbx_reject(mbx_reject));

// >>> verif/lrp_flash_model.sv
`timescale 1ns/1ps
// configuration flash stand-in: answers each read after a settable wait
module lrp_flash_model #(
    parameter bit LARGE_VARIANT = 1'b0
) (
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        rst,
    // read port
    input wire logic        flash_rd,
    input wire logic [31:0] flash_addr,
    output logic            flash_valid,
    output logic [31:0]     flash_data,
    // stored contents and answer delay
    input wire logic [31:0] word_val,
    input wire logic [31:0] copy_val,
    input wire logic [3:0]  dly
);
    logic [31:0] held_reg;
    logic [31:0] addr_reg;
    logic [3:0]  cnt_reg;
    logic        pend_reg;
    // data is not held past the valid cycle, so show a changed value
    assign flash_data = flash_valid ? held_reg : ~held_reg;
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            flash_valid <= 1'b0;
            pend_reg <= 1'b0;
            held_reg <= 32'h0;
        end else begin
            flash_valid <= 1'b0;
            if (flash_rd) begin
                pend_reg <= 1'b1;
                cnt_reg <= dly;
                addr_reg <= flash_addr;
            end else if (pend_reg && cnt_reg == 4'h0) begin
                pend_reg <= 1'b0;
                flash_valid <= 1'b1;
                // an unknown location returns zero, which no caller expects
                held_reg <= addr_reg == (LARGE_VARIANT ? lrp_pkg::ADDR_WORD_LARGE : lrp_pkg::ADDR_WORD_SMALL) ? word_val :
                            addr_reg == (LARGE_VARIANT ? lrp_pkg::ADDR_COPY_LARGE : lrp_pkg::ADDR_COPY_SMALL) ? copy_val :
                            32'h0;
            end else if (pend_reg) begin
                cnt_reg <= cnt_reg - 4'h1;
            end
        end
    end
endmodule : lrp_flash_model

// >>> verif/tb_top.sv
`timescale 1ns/1ps
// boots several protection words and checks gating, registers and loader decode
module tb_top;
    logic        ref_clk, rst, flash_rd, flash_valid, reg_wr, reg_rd, chip_reset, dbg_enable, dbg_locked;
    logic        isp_enable, boot_ready, mbx_valid, mbx_accept, mbx_reject, loader_go, loader_isp;
    logic [1:0]  level_out;
    logic [3:0]  mbx_cmd, loader_iface, dly, f;
    logic [7:0]  reg_addr;
    logic [31:0] flash_addr, flash_data, reg_wdata, reg_rdata, word_val, copy_val, rd_val, u;
    int          bad_count, total_checks;

    lrp_policy #(.LARGE_VARIANT(1'b1)) DUT (
        .ref_clk(ref_clk), .rst(rst), .flash_rd(flash_rd), .flash_addr(flash_addr), .flash_valid(flash_valid),
        .flash_data(flash_data), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .chip_reset(chip_reset), .dbg_enable(dbg_enable), .dbg_locked(dbg_locked),
        .isp_enable(isp_enable), .boot_ready(boot_ready), .level_out(level_out), .mbx_valid(mbx_valid),
        .mbx_cmd(mbx_cmd), .mbx_accept(mbx_accept), .mbx_reject(mbx_reject), .loader_go(loader_go),
        .loader_isp(loader_isp), .loader_iface(loader_iface));
    lrp_flash_model #(.LARGE_VARIANT(1'b1)) u_flash (
        .ref_clk(ref_clk), .rst(rst), .flash_rd(flash_rd), .flash_addr(flash_addr), .flash_valid(flash_valid),
        .flash_data(flash_data), .word_val(word_val), .copy_val(copy_val), .dly(dly));

    // bench model: commands open per level, 4 stands for an unknown word
    function automatic logic [9:0] allowed(int lv);
        int q[$];
        logic [9:0] m;
        m = 10'h0;
        if (lv == 0) q = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9};
        else if (lv == 1) q = '{0, 2, 3, 4, 5, 1};
        else if (lv == 2) q = '{0, 2, 3, 5, 1};
        foreach (q[i]) m[q[i]] = 1'b1;
        return m;
    endfunction : allowed

    task automatic chk(logic [31:0] got, logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task end_sim;
        if (bad_count == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim

    task automatic reg_write(logic [7:0] a, logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    // read data stands only in the cycle after the strobe
    task automatic reg_read(logic [7:0] a);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 rd_val = reg_rdata;
    endtask : reg_read

    task automatic mbx_send(logic [3:0] c, logic exp);
        @(posedge ref_clk);
        mbx_valid <= 1'b1;
        mbx_cmd <= c;
        @(posedge ref_clk);
        mbx_valid <= 1'b0;
        #1 chk(mbx_accept, exp);
        chk(mbx_reject, !exp);
    endtask : mbx_send

    // full reset of 20 cycles, then wait bounded for start-up to settle
    task automatic boot(logic [31:0] w, logic [31:0] c);
        int n;
        @(posedge ref_clk);
        rst <= 1'b1;
        word_val <= w;
        copy_val <= c;
        dly <= 4'($urandom_range(0, 6));
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        n = 0;
        while (boot_ready !== 1'b1 && chip_reset !== 1'b1 && n < 200) begin
            @(posedge ref_clk);
            n++;
        end
        @(posedge ref_clk);
        #1;
    endtask : boot

    task automatic check_level(logic [31:0] w, int lv);
        logic [9:0] m;
        boot(w, w);
        m = allowed(lv);
        chk(boot_ready, 1'b1);
        chk(level_out, (lv > 3) ? 3 : lv);
        chk({dbg_enable, dbg_locked}, {lv == 0, lv >= 2});
        if (lv != 1 && lv != 2) chk(isp_enable, lv == 0);
        reg_read(lrp_pkg::OFS_LEVEL_WORD);
        chk(rd_val, w);
        reg_read(lrp_pkg::OFS_STATUS);
        chk({rd_val[6], rd_val[4:0]}, {1'b1, lv >= 2, lv == 0, 3'(lv)});
        for (int c = 0; c < 10; c++) mbx_send(4'(c), m[c]);
    endtask : check_level

    task automatic loader(logic [31:0] arg, logic ok, logic in_system_programming);
        reg_write(lrp_pkg::OFS_LOADER_ARG, arg);
        reg_read(lrp_pkg::OFS_LOADER_RES);
        chk(rd_val[1:0], {in_system_programming, ok});
        chk({loader_go, loader_isp}, {ok, in_system_programming});
        if (ok) chk({rd_val[5:2], loader_iface}, {arg[19:16], arg[19:16]});
    endtask : loader

    initial begin
        ref_clk = 1'b0;
        forever begin
            #25 ref_clk = ~ref_clk;
        end
    end

    // watchdog far beyond the few hundred cycles the sequence needs
    initial begin
        #1000000;
        bad_count++;
        end_sim();
    end

    initial begin
        {rst, reg_wr, reg_rd, mbx_valid} = 4'hf;
        {reg_wr, reg_rd, mbx_valid} = 3'h0;
        {reg_addr, reg_wdata, mbx_cmd, dly} = '0;
        word_val = lrp_pkg::ENC_LEVEL_ZERO;
        copy_val = lrp_pkg::ENC_LEVEL_ZERO;
        bad_count = 0;
        total_checks = 0;
        void'($urandom(32'hbb962330));
        check_level(lrp_pkg::ENC_LEVEL_ZERO, 0);
        // loader argument: tagged requests in both modes, then broken fields
        f = 4'($urandom_range(0, 5));
        loader(32'heb100000 | {12'h0, f, 16'h0}, 1'b1, 1'b1);
        loader(32'heb000000, 1'b1, 1'b0);
        loader(32'hea100000, 1'b0, 1'b0);
        loader(32'heb200000, 1'b0, 1'b0);
        loader(32'heb160000, 1'b0, 1'b0);
        reg_read(8'h10);
        chk(rd_val, 32'h0);
        check_level(lrp_pkg::ENC_LEVEL_ONE, 1);
        // a write that lowers the rank is dropped, a raising one is kept
        reg_write(lrp_pkg::OFS_LEVEL_WORD, lrp_pkg::ENC_LEVEL_ZERO);
        reg_read(lrp_pkg::OFS_LEVEL_WORD);
        chk(rd_val, lrp_pkg::ENC_LEVEL_ONE);
        reg_write(lrp_pkg::OFS_LEVEL_WORD, lrp_pkg::ENC_LEVEL_TWO);
        reg_read(lrp_pkg::OFS_LEVEL_WORD);
        chk(rd_val, lrp_pkg::ENC_LEVEL_TWO);
        reg_write(lrp_pkg::OFS_LEVEL_WORD, lrp_pkg::ENC_LEVEL_ONE);
        reg_read(lrp_pkg::OFS_LEVEL_WORD);
        chk(rd_val, lrp_pkg::ENC_LEVEL_TWO);
        chk(level_out, 32'h1);
        mbx_send(lrp_pkg::CMD_ENTER_PROG, 1'b1);
        check_level(lrp_pkg::ENC_LEVEL_TWO, 2);
        check_level(lrp_pkg::ENC_LEVEL_THREE, 3);
        loader(32'heb100000, 1'b1, 1'b0);
        // masked random word can never equal one of the four encodings
        u = $urandom & 32'h7ffffff0;
        check_level(u, 4);
        boot(lrp_pkg::ENC_LEVEL_ZERO, lrp_pkg::ENC_LEVEL_ONE);
        chk({chip_reset, boot_ready, dbg_enable}, 3'b100);
        mbx_send(lrp_pkg::CMD_START_SESSION, 1'b0);
        end_sim();
    end
endmodule : tb_top
